/* rtl/pss_pkg.sv */
// Shared constants and types for the power supply sequencer.
// Assumes a single 10 MHz clock and an APB register port.
package pss_pkg;
	localparam int PSS_CH = 4;
	localparam int PSS_CLK_HZ = 10_000_000;
	// Register byte offsets
	localparam logic [7:0] PSS_CTRL_OFS = 8'h00;
	localparam logic [7:0] PSS_DLY_OFS = 8'h04;
	localparam logic [7:0] PSS_TMO_OFS = 8'h08;
	localparam logic [7:0] PSS_STAT_OFS = 8'h0c;
	// Control field positions
	localparam int PSS_CTRL_DLY_EN_BIT = 0;
	localparam int PSS_CTRL_TMO_EN_BIT = 1;
	// Reset values
	localparam logic [1:0] PSS_CTRL_RST = 2'h0;
	localparam logic [23:0] PSS_DLY_RST = 24'h000000;
	localparam logic [23:0] PSS_TMO_RST = 24'h000000;
	// Minimum stage delay when unconfigured: 1 us
	localparam int PSS_MIN_DLY_US = 1;
	localparam int PSS_MIN_DLY_CYC = (PSS_MIN_DLY_US * PSS_CLK_HZ + 999_999) / 1_000_000;
	// External fault must be held at least 1 us
	localparam int PSS_XFLT_US = 1;
	localparam int PSS_XFLT_CYC = (PSS_XFLT_US * PSS_CLK_HZ + 999_999) / 1_000_000;
	localparam logic [23:0] PSS_MIN_DLY = 24'(PSS_MIN_DLY_CYC);
	localparam logic [3:0] PSS_XFLT_N = 4'(PSS_XFLT_CYC);
	typedef enum logic [2:0] {
		PSS_IDLE = 3'b000,
		PSS_ON_DLY = 3'b001,
		PSS_ON_WAIT = 3'b011,
		PSS_DONE = 3'b010,
		PSS_OFF_WAIT = 3'b110,
		PSS_OFF_DLY = 3'b111,
		PSS_FAULT = 3'b100
	} pss_state_t;
endpackage

/* rtl/pss_timer_if.sv */
// Link between the sequencer and its cycle timer.
// Assumes both ends share ref_clk_i.
`timescale 1ns/1ns
interface pss_timer_if;
	logic clr;
	logic run;
	logic [23:0] limit;
	logic expired;
	modport ctl(output clr, output run, output limit, input expired);
	modport tmr(input clr, input run, input limit, output expired);
endinterface

/* rtl/pss_timer.sv */
// Held-reset cycle timer: counts while run, flags expiry at limit.
// Assumes clr has priority and limit is stable while running.
`timescale 1ns/1ns
module pss_timer
	import pss_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	pss_timer_if.tmr t
);
	typedef struct packed {
		logic [23:0] cnt;
		logic exp;
	} pss_tmr_st_t;
	pss_tmr_st_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (t.clr || !t.run) begin
			s_d.cnt = 24'h000000;
			s_d.exp = 1'b0;
		end else if (!s_q.exp) begin
			s_d.cnt = s_q.cnt + 24'h000001;
			s_d.exp = (s_q.cnt + 24'h000001) >= t.limit;
		end
	end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign t.expired = s_q.exp && t.run && !t.clr;
endmodule

/* rtl/pss_seq.sv */
// Four-channel power supply sequencer with APB configuration.
// Assumes sense, command and fault pins are asynchronous comparator levels.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
// How it works
// - Stage delay expiry after on-command starts pump and raises first enable.
// - Each asserted enable during power-on releases the rise-timeout timer.
// - Sense above threshold means supply on; hysteresis turned on.
// - Each supply on resets timeout, restarts delay, repeats until last.
// - After last supply on, completion flag pulls low.
// - Timeout before sense-on drops all enables and pulls error low.
// - Power-off starts only on command low after completed power-on.
// - Power-off drops enables in reverse order, fourth first.
// - Power-off uses stage delay after each sensed off but the last, no timeout.
// - End of power-off releases completion flag.
// - Power-on inserts stage delay between sensed-on and next enable.
// - Unconfigured stage delay uses the minimum delay.
// - Power-off removes hysteresis once the sense input falls.
// - Command dropping before completion is a fault.
// - External error pull-down is a fault; device holds error low until sense and command are low.
// - Fault clears only with all inputs low; an external fault also needs no external pull.
module pss_seq
	import pss_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic power_cmd_i,
	input wire logic [3:0] supply_sense_i,
	output logic [3:0] supply_enable_o,
	output logic [3:0] sense_hyst_o,
	output logic cmd_hyst_o,
	output logic pump_en_o,
	output logic done_n_o,
	output logic done_n_oe_o,
	input wire logic fault_n_i,
	output logic fault_n_o,
	output logic fault_n_oe_o,
	output logic int_fault_o
);
	// ==========================================
	// State
	typedef struct packed {
		logic [1:0] ctrl;
		logic [23:0] dly;
		logic [23:0] tmo;
		pss_state_t st;
		logic [1:0] idx;
		logic [3:0] en;
		logic [3:0] hys;
		logic pump;
		logic done;
		logic flt;
		logic flt_int;
		logic [3:0] xcnt;
		logic [5:0] s1;
		logic [5:0] s2;
		logic [31:0] rdata;
	} pss_seq_st_t;
	pss_seq_st_t s_q, s_d;
	pss_timer_if dly_if();
	pss_timer_if tmo_if();
	pss_timer u_dly (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.t(dly_if.tmr)
	);
	pss_timer u_tmo (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.t(tmo_if.tmr)
	);
	// ==========================================
	// Synchronised pins: s2 = {fault_n, cmd, sense[3:0]}
	logic [3:0] sense;
	logic cmd, xflt_pin;
	assign sense = s_q.s2[3:0];
	assign cmd = s_q.s2[4];
	assign xflt_pin = !s_q.s2[5];
	function automatic logic [31:0] pss_rd(input logic [7:0] a, input pss_seq_st_t s);
		logic [31:0] r;
		r = 32'h00000000;
		case (a)
			PSS_CTRL_OFS: r = {30'h0, s.ctrl};
			PSS_DLY_OFS: r = {8'h00, s.dly};
			PSS_TMO_OFS: r = {8'h00, s.tmo};
			PSS_STAT_OFS: r = {15'h0000, s.flt_int, s.flt, s.done, 1'b0, s.st, s.idx, s.hys, s.en};
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction
	logic apb_acc, apb_wr, addr_ok;
	assign apb_acc = psel_i && penable_i;
	assign apb_wr = apb_acc && pwrite_i;
	assign addr_ok = paddr_i == PSS_CTRL_OFS || paddr_i == PSS_DLY_OFS ||
		paddr_i == PSS_TMO_OFS || paddr_i == PSS_STAT_OFS;
	// ==========================================
	// Timers: gaps between stages and rise watchdog
	logic tmo_on;
	assign tmo_on = s_q.ctrl[PSS_CTRL_TMO_EN_BIT];
	assign dly_if.limit = (s_q.ctrl[PSS_CTRL_DLY_EN_BIT] && s_q.dly > PSS_MIN_DLY) ?
		s_q.dly : PSS_MIN_DLY;
	assign dly_if.run = s_q.st == PSS_ON_DLY || s_q.st == PSS_OFF_DLY;
	// Cleared between stages so every gap restarts from zero
	assign dly_if.clr = s_q.st == PSS_ON_WAIT || s_q.st == PSS_OFF_WAIT;
	assign tmo_if.limit = s_q.tmo;
	assign tmo_if.run = s_q.st == PSS_ON_WAIT && tmo_on;
	assign tmo_if.clr = s_q.st == PSS_ON_WAIT && sense[s_q.idx];
	// ==========================================
	// Sequencer
	always_comb begin
		s_d = s_q;
		s_d.s1 = {fault_n_i, power_cmd_i, supply_sense_i};
		s_d.s2 = s_q.s1;
		s_d.rdata = pss_rd(paddr_i, s_q);
		if (apb_wr) begin
			case (paddr_i)
				PSS_CTRL_OFS: s_d.ctrl = pwdata_i[1:0];
				PSS_DLY_OFS: s_d.dly = pwdata_i[23:0];
				PSS_TMO_OFS: s_d.tmo = pwdata_i[23:0];
				default: s_d.ctrl = s_q.ctrl;
			endcase
		end
		// External pull must persist the minimum time before it counts
		if (xflt_pin && !s_q.flt) begin
			if (s_q.xcnt < PSS_XFLT_N) begin
				s_d.xcnt = s_q.xcnt + 4'h1;
			end
		end else begin
			s_d.xcnt = 4'h0;
		end
		case (s_q.st)
			PSS_IDLE: begin
				if (cmd && s_q.en == 4'h0) begin
					s_d.st = PSS_ON_DLY;
					s_d.idx = 2'h0;
				end
			end
			PSS_ON_DLY: begin
				if (!cmd) begin
					s_d.st = PSS_FAULT;
					s_d.flt_int = 1'b1;
				end else if (dly_if.expired) begin
					s_d.pump = 1'b1;
					s_d.en[s_q.idx] = 1'b1;
					s_d.st = PSS_ON_WAIT;
				end
			end
			PSS_ON_WAIT: begin
				if (!cmd) begin
					s_d.st = PSS_FAULT;
					s_d.flt_int = 1'b1;
				end else if (sense[s_q.idx]) begin
					s_d.hys[s_q.idx] = 1'b1;
					if (s_q.idx == 2'(PSS_CH - 1)) begin
						s_d.st = PSS_DONE;
						s_d.done = 1'b1;
					end else begin
						s_d.idx = s_q.idx + 2'h1;
						s_d.st = PSS_ON_DLY;
					end
				end else if (tmo_if.expired) begin
					s_d.st = PSS_FAULT;
					s_d.flt_int = 1'b1;
				end
			end
			PSS_DONE: begin
				if (!cmd) begin
					s_d.idx = 2'(PSS_CH - 1);
					s_d.en[PSS_CH - 1] = 1'b0;
					s_d.st = PSS_OFF_WAIT;
				end else if (sense != 4'hf) begin
					s_d.st = PSS_FAULT;
					s_d.flt_int = 1'b1;
				end
			end
			PSS_OFF_WAIT: begin
				if (cmd) begin
					s_d.st = PSS_FAULT;
					s_d.flt_int = 1'b1;
				end else if (!sense[s_q.idx]) begin
					s_d.hys[s_q.idx] = 1'b0;
					if (s_q.idx == 2'h0) begin
						s_d.st = PSS_IDLE;
						s_d.done = 1'b0;
						s_d.pump = 1'b0;
					end else begin
						s_d.st = PSS_OFF_DLY;
					end
				end
			end
			PSS_OFF_DLY: begin
				if (cmd) begin
					s_d.st = PSS_FAULT;
					s_d.flt_int = 1'b1;
				end else if (dly_if.expired) begin
					s_d.idx = s_q.idx - 2'h1;
					s_d.en[s_q.idx - 2'h1] = 1'b0;
					s_d.st = PSS_OFF_WAIT;
				end
			end
			PSS_FAULT: begin
				// Commands ignored until everything is quiet
				// Own pull is let go first, else the wire could never read high
				if (sense == 4'h0 && !cmd && (s_q.flt_int || (!s_q.flt && !xflt_pin))) begin
					s_d.st = PSS_IDLE;
				end
			end
			default: s_d.st = PSS_IDLE;
		endcase
		// External fault overrides any sequencing state
		if (s_q.st != PSS_FAULT && s_q.xcnt == PSS_XFLT_N) begin
			s_d.st = PSS_FAULT;
		end
		if (s_d.st == PSS_FAULT) begin
			s_d.en = 4'h0;
			s_d.hys = 4'h0;
			s_d.pump = 1'b0;
			s_d.done = 1'b0;
			// External fault: release once quiet so the wire shows any outside pull
			s_d.flt = s_d.flt_int || s_q.st != PSS_FAULT || sense != 4'h0 || cmd;
			s_d.xcnt = 4'h0;
		end else begin
			s_d.flt = 1'b0;
			s_d.flt_int = 1'b0;
		end
	end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '0;
			s_q.ctrl <= PSS_CTRL_RST;
			s_q.dly <= PSS_DLY_RST;
			s_q.tmo <= PSS_TMO_RST;
			s_q.st <= PSS_IDLE;
			s_q.s1 <= 6'h20;
			s_q.s2 <= 6'h20;
		end else begin
			s_q <= s_d;
		end
	end
	// ==========================================
	// Outputs
	// Read data registered in setup phase, so zero wait states
	assign prdata_o = s_q.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = apb_acc && !addr_ok;
	assign supply_enable_o = s_q.en;
	assign sense_hyst_o = s_q.hys;
	assign cmd_hyst_o = cmd;
	assign pump_en_o = s_q.pump;
	assign done_n_o = 1'b0;
	assign done_n_oe_o = s_q.done;
	assign fault_n_o = 1'b0;
	assign fault_n_oe_o = s_q.flt;
	assign int_fault_o = s_q.flt_int;
	// ==========================================
	// Checks
	chk_first_enable: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_DLY && s_q.idx == 2'h0 && cmd && dly_if.expired && s_q.xcnt != PSS_XFLT_N)
		|=> (supply_enable_o == 4'h1 && pump_en_o))
		else $error("first enable not raised");
	chk_tmo_runs: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_WAIT && $past(s_q.st) == PSS_ON_WAIT && $past(tmo_on) && !$past(sense[s_q.idx]))
		|-> u_tmo.s_q.cnt != 24'h000000)
		else $error("timeout not running");
	chk_hyst_on: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_WAIT && cmd && sense[s_q.idx] && s_q.xcnt != PSS_XFLT_N)
		|=> $rose(sense_hyst_o[$past(s_q.idx)]))
		else $error("hysteresis not applied");
	chk_done_flag: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		done_n_oe_o |-> (supply_enable_o == 4'hf || s_q.st == PSS_OFF_WAIT || s_q.st == PSS_OFF_DLY))
		else $error("done without all supplies");
	chk_tmo_fault: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_WAIT && cmd && !sense[s_q.idx] && tmo_if.expired)
		|=> (supply_enable_o == 4'h0 && fault_n_oe_o))
		else $error("timeout fault missing");
	chk_off_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_DONE && !cmd && s_q.xcnt != PSS_XFLT_N) |=> supply_enable_o == 4'h7)
		else $error("power-off did not drop fourth first");
	chk_no_tmo_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_OFF_WAIT || s_q.st == PSS_OFF_DLY) |-> !tmo_if.run)
		else $error("timeout used in power-off");
	chk_fault_quiet: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_FAULT) |-> (supply_enable_o == 4'h0 && !done_n_oe_o &&
		(fault_n_oe_o || (!int_fault_o && !$past(cmd) && $past(sense) == 4'h0))))
		else $error("outputs active in fault");
	chk_cmd_drop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		((s_q.st == PSS_ON_DLY || s_q.st == PSS_ON_WAIT) && !cmd) |=> s_q.st == PSS_FAULT)
		else $error("early command drop not faulted");
	// ==========================================
	// Checks: stage timing
	chk_next_stage: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_WAIT && s_q.idx != 2'(PSS_CH - 1) && cmd && sense[s_q.idx] && s_q.xcnt != PSS_XFLT_N)
		|=> (s_q.st == PSS_ON_DLY && supply_enable_o == $past(supply_enable_o) && !tmo_if.run))
		else $error("next stage not delayed");
	chk_no_early_on: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_DLY && !dly_if.expired)
		|=> (supply_enable_o & ~$past(supply_enable_o)) == 4'h0)
		else $error("enable raised before stage delay");
	chk_min_delay: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		dly_if.expired |-> u_dly.s_q.cnt >= PSS_MIN_DLY)
		else $error("stage delay below minimum");
	chk_done_rise: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_WAIT && s_q.idx == 2'(PSS_CH - 1) && cmd && sense[s_q.idx] && s_q.xcnt != PSS_XFLT_N)
		|=> (done_n_oe_o && s_q.st == PSS_DONE))
		else $error("completion flag not pulled");
	chk_tmo_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_WAIT && !tmo_on && cmd && s_q.xcnt != PSS_XFLT_N)
		|=> s_q.st != PSS_FAULT)
		else $error("timeout fault while disabled");
	chk_off_step: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_OFF_WAIT && s_q.idx != 2'h0 && !cmd && !sense[s_q.idx] && s_q.xcnt != PSS_XFLT_N)
		|=> (s_q.st == PSS_OFF_DLY && supply_enable_o == $past(supply_enable_o) &&
		!sense_hyst_o[$past(s_q.idx)]))
		else $error("power-off step not delayed");
	chk_off_end: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_OFF_WAIT && s_q.idx == 2'h0 && !cmd && !sense[0] && s_q.xcnt != PSS_XFLT_N)
		|=> (s_q.st == PSS_IDLE && !done_n_oe_o && sense_hyst_o == 4'h0 && !pump_en_o))
		else $error("completion flag not released");
	// ==========================================
	// Checks: faults and start
	// An outside pull is only trusted after the minimum hold time
	chk_ext_fault: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st != PSS_FAULT && s_q.xcnt == PSS_XFLT_N)
		|=> (s_q.st == PSS_FAULT && supply_enable_o == 4'h0 && fault_n_oe_o))
		else $error("external fault not taken");
	chk_fault_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_FAULT && (sense != 4'h0 || cmd))
		|=> (s_q.st == PSS_FAULT && fault_n_oe_o))
		else $error("fault cleared while not quiet");
	chk_idle_start: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
		(s_q.st == PSS_ON_DLY && $past(s_q.st) != PSS_ON_DLY && $past(s_q.st) != PSS_ON_WAIT)
		|-> ($past(s_q.st) == PSS_IDLE && $past(supply_enable_o) == 4'h0 && !$past(done_n_oe_o)))
		else $error("power-on not started from idle");
endmodule

/* tb/pss_supply_model.sv */
// Behavioural supplies: each sense follows its enable after RISE cycles.
// Assumes the sequencer clock; a stuck bit never turns its supply on.
`timescale 1ns/1ns
module pss_supply_model #(
	parameter int RISE = 5
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic [3:0] en_i,
	input wire logic [3:0] stuck_i,
	output logic [3:0] sense_o
);
	int cnt[4];
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		for (int n = 0; n < 4; n++) begin
			if (!nrst_i) begin
				cnt[n] <= 0;
				sense_o[n] <= 1'b0;
			end else if (en_i[n] == sense_o[n] || (en_i[n] && stuck_i[n])) begin
				cnt[n] <= 0;
			end else if (cnt[n] == RISE - 1) begin
				sense_o[n] <= en_i[n];
				cnt[n] <= 0;
			end else begin
				cnt[n] <= cnt[n] + 1;
			end
		end
	end
endmodule

/* tb/tb_pss_seq.sv */
// Self-checking bench for the sequencer: APB setup, on/off, faults.
// Assumes supplies settle 5 cycles after their enable changes.
`timescale 1ns/1ns
module tb_pss_seq
	import pss_pkg::*;
;
	logic clk, nrst, psel, pen, pwr, pready, pslverr, cmd, chyst, pump;
	logic done_oe, flt_oe, int_flt, ext_pull, done_lvl, flt_lvl;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] sense, en, hyst, stuck;
	wire logic fault_n = !((flt_oe && !flt_lvl) || ext_pull);
	int mismatches, checks_done;
	pss_seq i_dut(.ref_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.power_cmd_i(cmd), .supply_sense_i(sense), .supply_enable_o(en), .sense_hyst_o(hyst),
		.cmd_hyst_o(chyst), .pump_en_o(pump), .done_n_o(done_lvl), .done_n_oe_o(done_oe), .fault_n_i(fault_n),
		.fault_n_o(flt_lvl), .fault_n_oe_o(flt_oe), .int_fault_o(int_flt));
	pss_supply_model i_sup(.ref_clk_i(clk), .nrst_i(nrst), .en_i(en), .stuck_i(stuck), .sense_o(sense));
	always #50 clk = ~clk;
	// =====
	// Shared tasks
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rng(input string nm, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
			report_and_stop();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	// Polls after each edge; sel 0 enables, 1 done pull, 2 fault pull
	task automatic wait_on(input int sel, input logic [3:0] exp, output int n);
		logic [3:0] v;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
			v = sel == 0 ? en : 4'(sel == 1 ? done_oe : flt_oe);
		end while (v !== exp && n < 2000);
		if (v !== exp) begin
			mismatches++;
			$display("CHECK FAILED wait %0d expected %h seen %h", sel, exp, v);
			report_and_stop();
		end
	endtask
	// =====
	// Scenarios
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		apb(1'b0, PSS_CTRL_OFS, 0, q, e);
		chk("ctrl", 0, q);
		apb(1'b0, PSS_STAT_OFS, 0, q, e);
		chk("status", 0, q);
		wr(PSS_DLY_OFS, 32'hff00_0014);
		apb(1'b0, PSS_DLY_OFS, 0, q, e);
		chk("dly", 32'h14, q);
		apb(1'b0, 8'h10, 0, q, e);
		chk("unmapped err", 1, 32'(e));
		chk("unmapped rd", 0, q);
		$display("regs done");
	endtask
	task automatic t_power();
		int n;
		wr(PSS_CTRL_OFS, 32'h1);
		@(posedge clk);
		cmd <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wait_on(0, 4'((1 << (i + 1)) - 1), n);
			rng("on step", 20, 33, n);
			chk("pump", 1, 32'(pump));
		end
		wait_on(1, 1, n);
		rng("done", 1, 12, n);
		chk("hyst", 32'hf, 32'(hyst));
		chk("cmd hyst", 1, 32'(chyst));
		chk("done lvl", 0, 32'(done_lvl));
		@(posedge clk);
		cmd <= 1'b0;
		wait_on(0, 4'h7, n);
		rng("off first", 1, 6, n);
		for (int i = 2; i >= 0; i--) begin
			wait_on(0, 4'((1 << i) - 1), n);
			rng("off step", 20, 33, n);
		end
		wait_on(1, 0, n);
		rng("done off", 1, 12, n);
		chk("hyst off", 0, 32'(hyst));
		$display("power done");
	endtask
	task automatic t_stall();
		int n;
		wr(PSS_DLY_OFS, 32'd40);
		wr(PSS_TMO_OFS, 32'd30);
		wr(PSS_CTRL_OFS, 32'h0);
		@(posedge clk);
		stuck <= 4'h2;
		cmd <= 1'b1;
		wait_on(0, 4'h1, n);
		rng("min dly", PSS_MIN_DLY_CYC, PSS_MIN_DLY_CYC + 6, n);
		wait_on(0, 4'h3, n);
		repeat (100) @(posedge clk);
		#1;
		chk("no tmo", 32'h30, {en, 3'h0, flt_oe});
		@(posedge clk);
		cmd <= 1'b0;
		wait_on(0, 4'h0, n);
		rng("drop", 1, 6, n);
		chk("drop flt", 32'h3, {30'h0, flt_oe, int_flt});
		chk("flt lvl", 0, 32'(flt_lvl));
		wait_on(2, 0, n);
		rng("clear", 3, 20, n);
		$display("stall done");
	endtask
	task automatic t_timeout();
		int n;
		wr(PSS_DLY_OFS, 32'd0);
		wr(PSS_CTRL_OFS, 32'h3);
		@(posedge clk);
		stuck <= 4'h4;
		cmd <= 1'b1;
		wait_on(0, 4'h7, n);
		wait_on(2, 1, n);
		rng("tmo", 30, 36, n);
		chk("tmo flt", 32'h1, {en, 3'h0, int_flt});
		repeat (50) @(posedge clk);
		#1;
		chk("held", 32'h1, {en, 3'h0, flt_oe});
		@(posedge clk);
		cmd <= 1'b0;
		stuck <= 4'h0;
		wait_on(2, 0, n);
		$display("timeout done");
	endtask
	task automatic t_ext();
		logic [31:0] q;
		logic e;
		int n;
		wr(PSS_CTRL_OFS, 32'h1);
		@(posedge clk);
		cmd <= 1'b1;
		wait_on(1, 1, n);
		@(posedge clk);
		ext_pull <= 1'b1;
		wait_on(0, 0, n);
		rng("ext", 10, 15, n);
		chk("ext flt", 32'h2, {30'h0, flt_oe, int_flt});
		repeat (5) @(posedge clk);
		ext_pull <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		chk("ext held", 1, 32'(flt_oe));
		@(posedge clk);
		cmd <= 1'b0;
		wait_on(2, 0, n);
		chk("idle", 0, 32'(done_oe));
		repeat (3) @(posedge clk);
		apb(1'b0, PSS_STAT_OFS, 0, q, e);
		chk("cleared", 0, q & 32'h0001_fc00);
		$display("ext done");
	endtask
	initial begin
		{clk, nrst, psel, pen, pwr, cmd, ext_pull} = '0;
		{paddr, pwdata, stuck} = '0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_power();
		t_stall();
		t_timeout();
		t_ext();
		report_and_stop();
	end
endmodule
